// >>> rtl/dss_pkg.sv
// Purpose: Shared constants, state type and helper functions of the drive start/stop sequencer.
// Assumes: CLK runs at 50 MHz; ramp and delay durations are kept in milliseconds.
// Notes: Register offsets are byte addresses on a 32-bit classic Wishbone bus.
package dss_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int HALT_MIN_MS = 100;
	// A halt must last longer than the minimum, hence one cycle beyond it.
	localparam int HALT_CYCLES = HALT_MIN_MS * (CLK_HZ / 1000) + 1;
	localparam int STOP_TIME_MS = 10000;

	// ----------------------------------------------------------------
	// Data widths and scale
	// ----------------------------------------------------------------
	localparam int DW = 16;
	localparam logic [DW-1:0] FULL_SCALE = 16'hFFFF;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_ACCEL = 8'h04;
	localparam logic [7:0] ADR_DECEL = 8'h08;
	localparam logic [7:0] ADR_STOP = 8'h0C;
	localparam logic [7:0] ADR_FAST = 8'h10;
	localparam logic [7:0] ADR_HOLD = 8'h14;
	localparam logic [7:0] ADR_SETPT = 8'h18;
	localparam logic [7:0] ADR_INCH = 8'h1C;
	localparam logic [7:0] ADR_TRIM = 8'h20;
	localparam logic [7:0] ADR_STATUS = 8'h24;
	localparam int CTRL_STOP_COAST = 0;
	localparam int CTRL_FAST_COAST = 1;
	localparam int CTRL_TRIM_EN = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [DW-1:0] ACCEL_RST = 16'h03E8;
	localparam logic [DW-1:0] DECEL_RST = 16'h03E8;
	localparam logic [DW-1:0] STOP_RST = DW'(STOP_TIME_MS / TICK_MS);
	localparam logic [DW-1:0] FAST_RST = 16'h01F4;
	localparam logic [DW-1:0] HOLD_RST = 16'h0064;

	typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_INCH, ST_DECEL, ST_TRIM, ST_DWELL} dss_state_e;

	// Linear step per tick; a zero duration means an immediate jump.
	function automatic logic [DW-1:0] ramp_step(input logic [DW-1:0] dur);
		if (dur == '0) return FULL_SCALE;
		return FULL_SCALE / dur;
	endfunction : ramp_step

	// Byte-lane merge of a write into a 16-bit register.
	function automatic logic [DW-1:0] wb_merge(input logic [DW-1:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
	endfunction : wb_merge

endpackage : dss_pkg

// >>> rtl/dss_ramp.sv
// Purpose: Linear ramp that moves a value toward a target once per tick.
// Assumes: tick is a one-cycle pulse; step is at least one.
// Notes: force_zero drops the value at the next edge, used for coasting.
`timescale 1ns/100ps
module dss_ramp import dss_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic tick,
	input wire logic force_zero,
	input wire logic [DW-1:0] target,
	input wire logic [DW-1:0] step,
	output logic [DW-1:0] value
);

	logic [DW-1:0] gap;

	assign gap = (value > target) ? value - target : target - value;

	always_ff @(posedge clk) begin
		if (reset || force_zero) begin
			value <= '0;
		end else if (tick && gap != '0) begin
			// Clamp the last step so the ramp lands exactly on the target.
			if (gap <= step) begin
				value <= target;
			end else if (value > target) begin
				value <= value - step;
			end else begin
				value <= value + step;
			end
		end
	end

endmodule : dss_ramp

// >>> rtl/dss_sequencer.sv
// Purpose: Start/stop sequencer turning run, jog and halt commands into a speed_setpoint_out.
// Assumes: All inputs are synchronous to CLK; halt inputs are active low.
// Notes: Registers are reached over classic Wishbone; ramps advance on a 1 ms tick.
//
// How it works
// - After reset stop mode is ramp and stop ramp time is ten seconds.
// - Ramp stop decelerates over decel_duration, then trim ramps to zero over stop time.
// - Without trim in use, the decel ramp alone brings the demand to zero.
// - After a ramp stop the stage stays enabled until the hold delay ends.
// - Zero decel_duration or freeze input makes a ramp stop use the stop-time rate; a fast halt keeps the fast rate.
// - Coast stop zeroes the demand and disables the stage at once.
// - Keypad and remote commands share one identical stop procedure.
// - Fast halt overrides run, reverse and jog in both command modes.
// - Fast halt mode is ramp or coast, starting when its input goes low.
// - Freewheel halt low disables the power stage immediately.
// - Freewheel halt has priority; fast halt is ignored while it is active.
// - A trip coasts the drive and blocks the stage until cleared and reset.
// - Halt-latch low over 100 ms starts a stop that always completes.
// - Permit low disables the stage; every start needs the permit.
// - In remote mode, with halt-latch low the drive runs only while run is held.
// - In remote mode run and reverse both true are ignored and the drive stops.
// - Halt-latch high latches remote run requests; low unlatches them and stops.
// - Jog is never latched; the drive jogs only while jog is held.
// - Run and jog are exclusive; switching needs a stop first.
// - Motion-active is true from start until the stop sequence completes.
// - Fault-free is true whenever the drive is not tripped.
`timescale 1ns/100ps
module dss_sequencer import dss_pkg::*; #(
	parameter int P_TICK_CYCLES = TICK_CYCLES,
	parameter int P_HALT_CYCLES = HALT_CYCLES
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic LOCAL_MODE,
	input wire logic KEY_RUN,
	input wire logic KEY_STOP,
	input wire logic KEY_INCH,
	input wire logic KEY_REVERSE,
	input wire logic RUN_FWD,
	input wire logic RUN_REV,
	input wire logic INCH_REQUEST,
	input wire logic FAST_HALT_N,
	input wire logic FREEWHEEL_HALT_N,
	input wire logic HALT_LATCH_N,
	input wire logic STAGE_PERMIT,
	input wire logic RAMP_FREEZE,
	input wire logic TRIP,
	input wire logic TRIP_RESET,
	output logic [DW-1:0] SPEED_SETPOINT_OUT,
	output logic [DW-1:0] TRIM_OUT,
	output logic DIRECTION_FROM_SEQUENCER,
	output logic STAGE_ENABLE,
	output logic MOTION_ACTIVE,
	output logic FAULT_FREE
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	dss_state_e state, next_state;
	logic next_stage, next_dir, next_fast;
	logic [2:0] ctrl;
	logic [DW-1:0] accel_ms, decel_ms, stop_ms, fast_ms, hold_ms;
	logic [DW-1:0] setpoint, inch_set, trim_set;
	logic [15:0] tick_cnt;
	logic tick;
	logic [23:0] halt_cnt;
	logic stop_pend, trip_lat, fwd_lat, rev_lat, key_lat, fast_stop;
	logic [DW-1:0] dwell_cnt;
	logic wb_hit;
	logic [31:0] rd_mux;
	logic stop_coast, fast_coast, trim_en;
	logic fwd_any, rev_any, run_req, inch_req, rev_req, coast_now;
	logic halt_fast, stop_cmd, zero_now;
	logic [DW-1:0] main_tgt, main_step, trim_tgt, trim_step;
	logic [DW-1:0] acc_step, dec_step, stp_step, fst_step;

	assign stop_coast = ctrl[CTRL_STOP_COAST];
	assign fast_coast = ctrl[CTRL_FAST_COAST];
	assign trim_en = ctrl[CTRL_TRIM_EN];
	assign acc_step = ramp_step(accel_ms);
	assign dec_step = ramp_step(decel_ms);
	assign stp_step = ramp_step(stop_ms);
	assign fst_step = ramp_step(fast_ms);

	// ----------------------------------------------------------------
	// System tick
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else if (tick_cnt == 16'(P_TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone register file
	// ----------------------------------------------------------------
	assign wb_hit = WB_CYC_I && WB_STB_I;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= wb_hit && !WB_ACK_O;
		end
	end

	always_comb begin
		case (WB_ADR_I)
			ADR_CTRL: rd_mux = {29'h0, ctrl};
			ADR_ACCEL: rd_mux = {16'h0, accel_ms};
			ADR_DECEL: rd_mux = {16'h0, decel_ms};
			ADR_STOP: rd_mux = {16'h0, stop_ms};
			ADR_FAST: rd_mux = {16'h0, fast_ms};
			ADR_HOLD: rd_mux = {16'h0, hold_ms};
			ADR_SETPT: rd_mux = {16'h0, setpoint};
			ADR_INCH: rd_mux = {16'h0, inch_set};
			ADR_TRIM: rd_mux = {16'h0, trim_set};
			ADR_STATUS: rd_mux = {25'h0, trip_lat, STAGE_ENABLE, MOTION_ACTIVE, fast_stop,
				3'(state)};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			WB_DAT_O <= 32'h0;
		end else if (wb_hit && !WB_ACK_O && !WB_WE_I) begin
			WB_DAT_O <= rd_mux;
		end
	end

	// Writes land on the edge where the master sees the acknowledge.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctrl <= CTRL_RST;
			accel_ms <= ACCEL_RST;
			decel_ms <= DECEL_RST;
			stop_ms <= STOP_RST;
			fast_ms <= FAST_RST;
			hold_ms <= HOLD_RST;
			setpoint <= '0;
			inch_set <= '0;
			trim_set <= '0;
		end else if (wb_hit && WB_ACK_O && WB_WE_I) begin
			case (WB_ADR_I)
				ADR_CTRL: if (WB_SEL_I[0]) ctrl <= WB_DAT_I[2:0];
				ADR_ACCEL: accel_ms <= wb_merge(accel_ms, WB_DAT_I, WB_SEL_I);
				ADR_DECEL: decel_ms <= wb_merge(decel_ms, WB_DAT_I, WB_SEL_I);
				ADR_STOP: stop_ms <= wb_merge(stop_ms, WB_DAT_I, WB_SEL_I);
				ADR_FAST: fast_ms <= wb_merge(fast_ms, WB_DAT_I, WB_SEL_I);
				ADR_HOLD: hold_ms <= wb_merge(hold_ms, WB_DAT_I, WB_SEL_I);
				ADR_SETPT: setpoint <= wb_merge(setpoint, WB_DAT_I, WB_SEL_I);
				ADR_INCH: inch_set <= wb_merge(inch_set, WB_DAT_I, WB_SEL_I);
				ADR_TRIM: trim_set <= wb_merge(trim_set, WB_DAT_I, WB_SEL_I);
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Command latches and halt filter
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			fwd_lat <= 1'b0;
			rev_lat <= 1'b0;
			key_lat <= 1'b0;
		end else begin
			// The forward and reverse latches only hold while the halt-latch input stays high; the keypad latch ignores it.
			fwd_lat <= HALT_LATCH_N && !RUN_REV && (RUN_FWD || fwd_lat);
			rev_lat <= HALT_LATCH_N && !RUN_FWD && (RUN_REV || rev_lat);
			key_lat <= !KEY_STOP && (KEY_RUN || key_lat);
		end
	end

	// The filter fires once per low period, so a permanently low input
	// still allows plain held-run operation.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			halt_cnt <= '0;
			stop_pend <= 1'b0;
		end else begin
			if (HALT_LATCH_N) begin
				halt_cnt <= '0;
			end else if (halt_cnt != 24'(P_HALT_CYCLES)) begin
				halt_cnt <= halt_cnt + 24'h000001;
			end
			if (!HALT_LATCH_N && halt_cnt == 24'(P_HALT_CYCLES - 1)) begin
				stop_pend <= 1'b1;
			end else if (state == ST_IDLE) begin
				stop_pend <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			trip_lat <= 1'b0;
			FAULT_FREE <= 1'b1;
		end else begin
			trip_lat <= TRIP || (trip_lat && !TRIP_RESET);
			FAULT_FREE <= !(TRIP || (trip_lat && !TRIP_RESET));
		end
	end

	assign fwd_any = RUN_FWD || fwd_lat;
	assign rev_any = RUN_REV || rev_lat;
	assign run_req = LOCAL_MODE ? key_lat : (fwd_any ^ rev_any);
	assign inch_req = LOCAL_MODE ? KEY_INCH : INCH_REQUEST;
	assign rev_req = LOCAL_MODE ? KEY_REVERSE : rev_any;
	assign coast_now = !FREEWHEEL_HALT_N || trip_lat || !STAGE_PERMIT;
	assign halt_fast = !FAST_HALT_N && FREEWHEEL_HALT_N;
	assign stop_cmd = halt_fast || stop_pend ||
		!(state == ST_RUN ? run_req : inch_req);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_stage = STAGE_ENABLE;
		next_dir = DIRECTION_FROM_SEQUENCER;
		next_fast = fast_stop;
		zero_now = 1'b0;
		case (state)
			ST_IDLE: begin
				next_stage = 1'b0;
				next_fast = 1'b0;
				if (!halt_fast && !stop_pend && STAGE_PERMIT) begin
					if (run_req) begin
						next_state = ST_RUN;
						next_stage = 1'b1;
						next_dir = rev_req;
					end else if (inch_req) begin
						next_state = ST_INCH;
						next_stage = 1'b1;
						next_dir = rev_req;
					end
				end
			end
			ST_RUN, ST_INCH: begin
				// The other request is not looked at here, so no swap without a stop.
				if (stop_cmd) begin
					next_fast = halt_fast;
					if (halt_fast ? fast_coast : stop_coast) begin
						next_state = ST_IDLE;
						next_stage = 1'b0;
						zero_now = 1'b1;
					end else begin
						next_state = ST_DECEL;
					end
				end
			end
			ST_DECEL: begin
				if (halt_fast) next_fast = 1'b1;
				if (SPEED_SETPOINT_OUT == '0) begin
					next_state = trim_en ? ST_TRIM : ST_DWELL;
				end
			end
			ST_TRIM: begin
				if (TRIM_OUT == '0) next_state = ST_DWELL;
			end
			ST_DWELL: begin
				if (tick && dwell_cnt >= hold_ms) begin
					next_state = ST_IDLE;
					next_stage = 1'b0;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_stage = 1'b0;
			end
		endcase
		// Forced coast overrides every state, including a running stop.
		if (coast_now) begin
			next_state = ST_IDLE;
			next_stage = 1'b0;
			zero_now = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			state <= ST_IDLE;
			STAGE_ENABLE <= 1'b0;
			DIRECTION_FROM_SEQUENCER <= 1'b0;
			MOTION_ACTIVE <= 1'b0;
			fast_stop <= 1'b0;
		end else begin
			state <= next_state;
			STAGE_ENABLE <= next_stage;
			DIRECTION_FROM_SEQUENCER <= next_dir;
			MOTION_ACTIVE <= next_state != ST_IDLE;
			fast_stop <= next_fast;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET || state != ST_DWELL) begin
			dwell_cnt <= '0;
		end else if (tick && dwell_cnt != FULL_SCALE) begin
			dwell_cnt <= dwell_cnt + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Ramps
	// ----------------------------------------------------------------
	always_comb begin
		main_tgt = '0;
		main_step = acc_step;
		case (state)
			ST_RUN: main_tgt = setpoint;
			ST_INCH: main_tgt = inch_set;
			ST_DECEL: begin
				if (fast_stop) main_step = fst_step;
				else if (decel_ms == '0 || RAMP_FREEZE) main_step = stp_step;
				else main_step = dec_step;
			end
			default: main_step = acc_step;
		endcase
		trim_tgt = (state == ST_RUN || state == ST_INCH || state == ST_DECEL) ? trim_set : '0;
		trim_step = (state == ST_TRIM) ? stp_step : acc_step;
	end

	dss_ramp u_main_ramp (
		.clk(CLK),
		.reset(RESET),
		.tick(tick),
		.force_zero(zero_now),
		.target(main_tgt),
		.step(main_step),
		.value(SPEED_SETPOINT_OUT)
	);

	dss_ramp u_trim_ramp (
		.clk(CLK),
		.reset(RESET),
		.tick(tick),
		.force_zero(zero_now || !trim_en),
		.target(trim_tgt),
		.step(trim_step),
		.value(TRIM_OUT)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	a_reset_stop_mode: assert property ($fell(RESET) |->
		!stop_coast && stop_ms == STOP_RST)
		else $error("Stop mode or stop time wrong after reset.");
	a_decel_to_trim: assert property (state == ST_DECEL && SPEED_SETPOINT_OUT == '0
		&& !coast_now && trim_en |=> state == ST_TRIM)
		else $error("Decel end did not start trim ramp.");
	a_no_trim_skip: assert property (state == ST_DECEL && !trim_en |=> state != ST_TRIM)
		else $error("Trim stage entered with trim off.");
	a_dwell_holds: assert property (state == ST_DWELL && !coast_now
		&& !(tick && dwell_cnt >= hold_ms) |=> STAGE_ENABLE)
		else $error("Stage dropped before hold delay.");
	a_freeze_rate: assert property (state == ST_DECEL && !fast_stop && RAMP_FREEZE
		|-> main_step == stp_step)
		else $error("Frozen stop not at stop-time rate.");
	a_coast_now: assert property (coast_now |=> !STAGE_ENABLE && SPEED_SETPOINT_OUT == '0
		&& !MOTION_ACTIVE)
		else $error("Coast did not drop stage and demand.");
	a_fast_blocks: assert property (state == ST_IDLE && !FAST_HALT_N |=> state == ST_IDLE)
		else $error("Start accepted during fast halt.");
	a_fast_stops: assert property ((state == ST_RUN || state == ST_INCH) && halt_fast
		&& !coast_now |=> state == (fast_coast ? ST_IDLE : ST_DECEL))
		else $error("Fast halt did not begin its stop.");
	a_halt_latch: assert property (stop_pend && state != ST_IDLE && !coast_now
		|=> state != ST_RUN && state != ST_INCH)
		else $error("Latched halt did not stop the drive.");
	a_both_ignored: assert property (state == ST_IDLE && !LOCAL_MODE && RUN_FWD && RUN_REV
		|=> state != ST_RUN)
		else $error("Run and reverse together started the drive.");
	a_run_inch_excl: assert property (state == ST_RUN |=> state != ST_INCH)
		else $error("Run changed to jog without a stop.");
	a_motion_flag: assert property (MOTION_ACTIVE == (state != ST_IDLE))
		else $error("Motion flag disagrees with sequencer.");
	a_fault_free: assert property (FAULT_FREE == !trip_lat)
		else $error("Fault-free flag disagrees with trip.");
	a_wb_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("Acknowledge held for two cycles.");

	c_ramp_stop: cover property (state == ST_DECEL ##1 state == ST_DWELL);
	c_trim_stop: cover property (state == ST_TRIM ##1 state == ST_DWELL);
	c_fast_stop: cover property (state == ST_RUN && halt_fast ##1 state == ST_DECEL);
	c_inch_run: cover property (state == ST_INCH ##1 state == ST_DECEL);

endmodule : dss_sequencer

// >>> sim/dss_stage_model.sv
// Purpose: Power stage stand-in that reports an injected fault back as a trip.
// Assumes: fault_cmd comes from the bench and is held for several cycles.
// Notes: A fault only shows while the stage is energised, then holds until removed.
`timescale 1ns/100ps
module dss_stage_model (
	input wire logic clk,
	input wire logic stage_enable,
	input wire logic fault_cmd,
	output logic trip = 1'b0
);
	// The flag outlives the stage enable, so a quenched stage still reports its fault.
	always_ff @(posedge clk) begin
		trip <= fault_cmd & (stage_enable | trip);
	end
endmodule : dss_stage_model

// >>> sim/drive_start_stop_sequencer_tb.sv
// Purpose: Self-checking bench for the start/stop sequencer.
// Assumes: Tick of 10 cycles and halt filter of 20 cycles; all outputs are registered.
// Notes: Outputs are read at the edge before its updates land, so reads never race.
`timescale 1ns/100ps
module drive_start_stop_sequencer_tb import dss_pkg::*;;
	typedef struct {logic [7:0] a; logic [31:0] v;} dss_row_s;
	logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, ack, ff, se, ma, dir, trip;
	logic lm = 0, krun = 0, kstop = 0, krev = 0, rf = 0, rr = 0, inch = 0, trst = 0;
	logic fh = 1, fw = 1, hl = 0, perm = 1, fault = 0, kinch = 0, frz = 0;
	logic [7:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wd = '0, rd, q;
	logic [DW-1:0] spd, trim;
	int n_fail = 0, samples_checked = 0, n;
	dss_row_s rows[8] = '{'{8'h00, 32'h0}, '{8'h04, 32'h3E8}, '{8'h08, 32'h3E8},
		'{8'h0C, 32'h2710}, '{8'h10, 32'h1F4}, '{8'h14, 32'h64}, '{8'h18, 32'h0},
		'{8'h30, 32'h0}};

	always #10 clk = ~clk;

	dss_sequencer #(.P_TICK_CYCLES(10), .P_HALT_CYCLES(20)) uut (.CLK(clk), .RESET(rst),
		.WB_ADR_I(adr), .WB_DAT_I(wd), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_DAT_O(q), .WB_ACK_O(ack), .LOCAL_MODE(lm), .KEY_RUN(krun),
		.KEY_STOP(kstop), .KEY_INCH(kinch), .KEY_REVERSE(krev), .RUN_FWD(rf), .RUN_REV(rr),
		.INCH_REQUEST(inch), .FAST_HALT_N(fh), .FREEWHEEL_HALT_N(fw), .HALT_LATCH_N(hl),
		.STAGE_PERMIT(perm), .RAMP_FREEZE(frz), .TRIP(trip), .TRIP_RESET(trst),
		.SPEED_SETPOINT_OUT(spd), .TRIM_OUT(trim), .DIRECTION_FROM_SEQUENCER(dir),
		.STAGE_ENABLE(se), .MOTION_ACTIVE(ma), .FAULT_FREE(ff));

	dss_stage_model pm (.clk(clk), .stage_enable(se), .fault_cmd(fault), .trip(trip));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task tk(input int k);
		repeat (k) @(posedge clk);
	endtask : tk

	// A slave that never answers hangs this task until the 400000 ns watchdog ends the run as failed.
	task wb(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk);
		adr <= a;
		wd <= d;
		we <= w;
		sel <= 4'h3;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		chk(ack, 1'b1);
		rd = q;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task wait_se(input logic v, input int lim);
		n = 0;
		while (se !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(se, v);
	endtask : wait_se

	task wait_spd(input logic [DW-1:0] v);
		n = 0;
		while (spd !== v && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk(spd, v);
	endtask : wait_spd

	task end_sim;
		$display("checks=%0d mismatches=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	initial begin
		#400000;
		n_fail++;
		end_sim;
	end

	initial begin
		tk(10);
		rst <= 1'b0;
		chk(ff, 1'b1);
		tk(40);
		foreach (rows[i]) begin
			wb(rows[i].a, 32'h0, 1'b0);
			chk(rd, rows[i].v);
		end
		$display("test reset_values done");
		wb(ADR_ACCEL, 32'h4, 1'b1);
		wb(ADR_DECEL, 32'h4, 1'b1);
		wb(ADR_HOLD, 32'h3, 1'b1);
		wb(ADR_SETPT, 32'h8000, 1'b1);
		rf <= 1'b1;
		wait_se(1'b1, 5);
		chk(ma, 1'b1);
		wait_spd(16'h8000);
		rf <= 1'b0;
		wait_spd(16'h0);
		tk(15);
		chk(se, 1'b1);
		wait_se(1'b0, 60);
		chk(ma, 1'b0);
		$display("test held_run done");
		rf <= 1'b1;
		rr <= 1'b1;
		tk(5);
		chk(se, 1'b0);
		rr <= 1'b0;
		fh <= 1'b0;
		tk(5);
		chk(se, 1'b0);
		fh <= 1'b1;
		perm <= 1'b0;
		tk(5);
		chk(se, 1'b0);
		perm <= 1'b1;
		wait_se(1'b1, 5);
		fw <= 1'b0;
		fh <= 1'b0;
		tk(3);
		chk(se, 1'b0);
		chk(spd, 16'h0);
		rf <= 1'b0;
		fw <= 1'b1;
		fh <= 1'b1;
		tk(5);
		$display("test refusals done");
		rf <= 1'b1;
		wait_se(1'b1, 5);
		fault <= 1'b1;
		rf <= 1'b0;
		tk(5);
		chk(se, 1'b0);
		chk(ff, 1'b0);
		fault <= 1'b0;
		rf <= 1'b1;
		tk(3);
		chk(ff, 1'b0);
		chk(se, 1'b0);
		trst <= 1'b1;
		tk(1);
		trst <= 1'b0;
		rf <= 1'b0;
		tk(4);
		chk(ff, 1'b1);
		$display("test trip done");
		wb(ADR_CTRL, 32'h1, 1'b1);
		lm <= 1'b1;
		krev <= 1'b1;
		krun <= 1'b1;
		tk(1);
		krun <= 1'b0;
		wait_se(1'b1, 5);
		chk(dir, 1'b1);
		tk(30);
		kstop <= 1'b1;
		tk(3);
		chk(se, 1'b0);
		chk(spd, 16'h0);
		kstop <= 1'b0;
		lm <= 1'b0;
		krev <= 1'b0;
		wb(ADR_CTRL, 32'h0, 1'b1);
		$display("test keypad_coast done");
		hl <= 1'b1;
		tk(3);
		rf <= 1'b1;
		tk(2);
		rf <= 1'b0;
		tk(30);
		chk(se, 1'b1);
		rf <= 1'b1;
		hl <= 1'b0;
		tk(25);
		// Run is still held here, so only the halt filter can have begun this stop.
		wb(ADR_STATUS, 32'h0, 1'b0);
		chk(rd, 32'h33);
		rf <= 1'b0;
		hl <= 1'b1;
		wait_se(1'b0, 300);
		chk(spd, 16'h0);
		wb(ADR_INCH, 32'h2000, 1'b1);
		inch <= 1'b1;
		wait_spd(16'h2000);
		inch <= 1'b0;
		wait_se(1'b0, 300);
		$display("test latch_and_jog done");
		hl <= 1'b0;
		wb(ADR_FAST, 32'h4, 1'b1);
		wb(ADR_STOP, 32'h8, 1'b1);
		tk(20);
		rf <= 1'b1;
		wait_spd(16'h8000);
		fh <= 1'b0;
		tk(3);
		chk(se, 1'b1);
		wait_spd(16'h0);
		wait_se(1'b0, 300);
		tk(3);
		chk(se, 1'b0);
		fh <= 1'b1;
		rf <= 1'b0;
		wb(ADR_CTRL, 32'h4, 1'b1);
		wb(ADR_TRIM, 32'h1000, 1'b1);
		rf <= 1'b1;
		wait_spd(16'h8000);
		chk(trim, 16'h1000);
		frz <= 1'b1;
		rf <= 1'b0;
		tk(25);
		// The stop-time rate is half the decel rate, so the demand is still high.
		chk(spd >= 16'h2003, 1'b1);
		wait_spd(16'h0);
		chk(trim, 16'h1000);
		tk(12);
		chk(trim, 16'h0);
		chk(se, 1'b1);
		wait_se(1'b0, 300);
		frz <= 1'b0;
		wb(ADR_CTRL, 32'h0, 1'b1);
		$display("test fast_trim_freeze done");
		lm <= 1'b1;
		fh <= 1'b0;
		kinch <= 1'b1;
		tk(5);
		chk(se, 1'b0);
		fh <= 1'b1;
		wait_se(1'b1, 5);
		kinch <= 1'b0;
		wait_se(1'b0, 300);
		lm <= 1'b0;
		$display("test keypad_jog done");
		rf <= 1'b1;
		wait_se(1'b1, 5);
		rst <= 1'b1;
		tk(2);
		rst <= 1'b0;
		rf <= 1'b0;
		chk(ma, 1'b0);
		chk(ff, 1'b1);
		wb(ADR_CTRL, 32'h0, 1'b0);
		chk(rd, 32'h0);
		wb(ADR_STOP, 32'h0, 1'b0);
		chk(rd, 32'h2710);
		$display("test mid_reset done");
		end_sim;
	end
endmodule : drive_start_stop_sequencer_tb
